// File: common/svdc_defs.svh
// register map, field positions, reset values and timing defaults of the supply voltage detector control
`ifndef SVDC_DEFS_SVH
`define SVDC_DEFS_SVH

`define SVDC_ADDR_W           3
`define SVDC_DATA_W           16

`define SVDC_ADDR_PROTECT     3'h0
`define SVDC_ADDR_CLOCK_CTRL  3'h1
`define SVDC_ADDR_CTRL        3'h2
`define SVDC_ADDR_FLAGS       3'h3
`define SVDC_ADDR_INT_ENABLE  3'h4

`define SVDC_PROTECT_UNLOCK   16'h0096
`define SVDC_RESET_CODE       4'hA
`define SVDC_MODE_CONTINUOUS  2'h0

`define SVDC_CLK_DEBUG_RUN_BIT    8
`define SVDC_CLK_DIV_MSB      6
`define SVDC_CLK_DIV_LSB      4
`define SVDC_CLK_SRC_MSB      1
`define SVDC_CLK_SRC_LSB      0
`define SVDC_CTL_SC_MSB       14
`define SVDC_CTL_SC_LSB       13
`define SVDC_CTL_THR_MSB      12
`define SVDC_CTL_THR_LSB      8
`define SVDC_CTL_RE_MSB       7
`define SVDC_CTL_RE_LSB       4
`define SVDC_CTL_MD_MSB       2
`define SVDC_CTL_MD_LSB       1
`define SVDC_CTL_EN_BIT       0
`define SVDC_FLAG_LOW_BIT     0
`define SVDC_FLAG_RESULT_BIT  8
`define SVDC_INTE_BIT         0

`define SVDC_INIT_DEBUG_RUN       1'b1
`define SVDC_INIT_DIV         3'h0
`define SVDC_INIT_SRC         2'h0
`define SVDC_INIT_THRESHOLD   5'h1E
`define SVDC_DIV_BYPASS_MIN   3'h6
`define SVDC_DIV_BASE         8'h04

`define SVDC_MASK_TICKS       4
`define SVDC_INTERVAL_MD1     256
`define SVDC_INTERVAL_MD2     512
`define SVDC_INTERVAL_MD3     1024

`endif

// File: common/svdc_pkg.sv
// types of the supply voltage detector control
package svdc_pkg;

  typedef enum logic [1:0] {
    SVDC_PH_IDLE   = 2'b00,
    SVDC_PH_WAIT   = 2'b01,
    SVDC_PH_POWER  = 2'b10,
    SVDC_PH_SAMPLE = 2'b11
  } svdc_phase_e;

  typedef struct packed {
    logic [15:0] protect_key;
    logic        debug_run;
    logic [2:0]  clock_divider_select;
    logic [1:0]  clock_source_select;
    logic [1:0]  low_count_select;
    logic [4:0]  threshold_select;
    logic [3:0]  reset_select;
    logic [1:0]  sampling_mode;
    logic        detect_enable;
    logic        low_voltage_flag;
    logic        detect_result;
    logic        low_voltage_int_enable;
    logic        reset_active;
    logic [6:0]  prescale;
    logic [3:0]  mask_cnt;
    logic [11:0] interval_cnt;
    logic [3:0]  low_cnt;
    svdc_phase_e phase;
    logic [15:0] rdata;
  } svdc_state_s;

endpackage

// File: test/svdc_properties.sv
// port-level assertion checker of the supply voltage detector control
`include "svdc_defs.svh"
module svdc_properties
  import svdc_pkg::*;
(
  // clock, reset and register port
  input wire logic                    clk_sys_in,
  input wire logic                    resetn_in,
  input wire logic [`SVDC_ADDR_W-1:0] addr_in,
  input wire logic [`SVDC_DATA_W-1:0] wdata_in,
  input wire logic                    wr_in,
  input wire logic                    rd_in,
  input wire logic [`SVDC_DATA_W-1:0] rdata_out,
  // sources, power states and comparator
  input wire logic [3:0]              src_tick_in,
  input wire logic                    sleep_in,
  input wire logic                    source_sleep_stop_in,
  input wire logic                    debug_in,
  input wire logic                    comp_low_in,
  input wire logic                    comp_enable_out,
  input wire logic [4:0]              threshold_select_out,
  // results
  input wire logic                    irq_out,
  input wire logic                    svd_reset_out,
  input wire logic                    detector_tick_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);

  sleep_tick_gate_a: assert property (sleep_in && source_sleep_stop_in |-> !detector_tick_out)
    else $error("detector tick while source stopped in sleep");
  tick_source_a: assert property (detector_tick_out |-> |src_tick_in)
    else $error("detector tick without a source tick");
  flag_hold_a: assert property (
    irq_out && !comp_low_in && !svd_reset_out
    && !(wr_in && addr_in inside {`SVDC_ADDR_FLAGS, `SVDC_ADDR_INT_ENABLE})
    |=> irq_out)
    else $error("interrupt request dropped without a clear");
  irq_cause_a: assert property (
    $rose(irq_out) |-> $past(wr_in && addr_in == `SVDC_ADDR_INT_ENABLE) || $past(comp_low_in))
    else $error("interrupt request without flag or enable cause");
  reset_hold_a: assert property (svd_reset_out && comp_low_in && $past(comp_low_in) |=> svd_reset_out)
    else $error("reset request released while supply low");
  reset_comp_a: assert property (svd_reset_out |-> comp_enable_out)
    else $error("comparator off in reset state");
  reset_irq_a: assert property ($rose(svd_reset_out) |=> !irq_out)
    else $error("interrupt request in reset state");
  thr_write_a: assert property (
    $changed(threshold_select_out) |-> $past(wr_in && addr_in == `SVDC_ADDR_CTRL)
    || $past(wr_in && addr_in == `SVDC_ADDR_CTRL, 2))
    else $error("threshold changed without a control write");
  rdata_hold_a: assert property (!$past(rd_in) |-> $stable(rdata_out))
    else $error("read data changed without a read");
endmodule // svdc_properties

bind svdc_supply_voltage_detector svdc_properties u_props (
  .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
  .rd_in(rd_in), .rdata_out(rdata_out), .src_tick_in(src_tick_in), .sleep_in(sleep_in),
  .source_sleep_stop_in(source_sleep_stop_in), .debug_in(debug_in), .comp_low_in(comp_low_in),
  .comp_enable_out(comp_enable_out), .threshold_select_out(threshold_select_out), .irq_out(irq_out),
  .svd_reset_out(svd_reset_out), .detector_tick_out(detector_tick_out));

// File: test/svdc_supply_voltage_detector_ctrl_bench.sv
// self-checking testbench of the supply voltage detector control
`include "svdc_defs.svh"
module svdc_supply_voltage_detector_ctrl_bench
  import svdc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                    clk_sys_in, resetn_in, wr_in, rd_in, sleep_in, source_sleep_stop_in, debug_in;
  logic                    comp_low_in, comp_enable_out, irq_out, svd_reset_out, detector_tick_out;
  logic [`SVDC_ADDR_W-1:0] addr_in;
  logic [`SVDC_DATA_W-1:0] wdata_in, rdata_out;
  logic [3:0]              src_tick_in;
  logic [4:0]              threshold_select_out;
  int                      fail_count, samples_checked, cycles;

  svdc_supply_voltage_detector #(.MASK_TICKS(2), .INTERVAL_MD1(2), .INTERVAL_MD2(3), .INTERVAL_MD3(4)) DUT (
    .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
    .rd_in(rd_in), .rdata_out(rdata_out), .src_tick_in(src_tick_in), .sleep_in(sleep_in),
    .source_sleep_stop_in(source_sleep_stop_in), .debug_in(debug_in), .comp_low_in(comp_low_in),
    .comp_enable_out(comp_enable_out), .threshold_select_out(threshold_select_out), .irq_out(irq_out),
    .svd_reset_out(svd_reset_out), .detector_tick_out(detector_tick_out));

  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      close_out();
    end
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk_sys_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
  endtask

  task automatic rd_check(input string what, input logic [2:0] a, input logic [15:0] exp);
    @(posedge clk_sys_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    @(negedge clk_sys_in);
    check(what, exp, rdata_out);
  endtask

  task automatic reset_values();
    rd_check("clock ctrl", `SVDC_ADDR_CLOCK_CTRL, 16'h0100);
    rd_check("ctrl", `SVDC_ADDR_CTRL, 16'h1E00);
    rd_check("flags", `SVDC_ADDR_FLAGS, 16'h0000);
    rd_check("int enable", `SVDC_ADDR_INT_ENABLE, 16'h0000);
    rd_check("key", `SVDC_ADDR_PROTECT, 16'h0000);
    rd_check("unmapped", 3'h7, 16'h0000);
    check("threshold pin", 16'h001E, {11'h000, threshold_select_out});
  endtask

  task automatic protect_scn();
    wr(`SVDC_ADDR_CTRL, 16'h0501);
    rd_check("locked ctrl", `SVDC_ADDR_CTRL, 16'h1E00);
    check("comparator off", 16'h0000, {15'h0000, comp_enable_out});
    wr(`SVDC_ADDR_PROTECT, `SVDC_PROTECT_UNLOCK);
    wr(`SVDC_ADDR_CTRL, 16'h0500);
    rd_check("threshold field", `SVDC_ADDR_CTRL, 16'h0500);
    check("threshold pin", 16'h0005, {11'h000, threshold_select_out});
    wr(`SVDC_ADDR_PROTECT, 16'h0000);
    wr(`SVDC_ADDR_CTRL, 16'h1E00);
    rd_check("relocked ctrl", `SVDC_ADDR_CTRL, 16'h0500);
    wr(`SVDC_ADDR_PROTECT, `SVDC_PROTECT_UNLOCK);
  endtask

  task automatic continuous_scn();
    wr(`SVDC_ADDR_CLOCK_CTRL, 16'h0160);
    wr(`SVDC_ADDR_FLAGS, 16'h0001);
    wr(`SVDC_ADDR_INT_ENABLE, 16'h0001);
    wr(`SVDC_ADDR_CTRL, 16'h1E01);
    repeat (8) @(posedge clk_sys_in);
    rd_check("result good", `SVDC_ADDR_FLAGS, 16'h0000);
    @(posedge clk_sys_in);
    comp_low_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    rd_check("flag and result", `SVDC_ADDR_FLAGS, 16'h0101);
    check("irq on low", 16'h0001, {15'h0000, irq_out});
    @(posedge clk_sys_in);
    comp_low_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    rd_check("flag kept", `SVDC_ADDR_FLAGS, 16'h0001);
    wr(`SVDC_ADDR_INT_ENABLE, 16'h0000);
    rd_check("flag masked", `SVDC_ADDR_FLAGS, 16'h0001);
    check("irq masked", 16'h0000, {15'h0000, irq_out});
    wr(`SVDC_ADDR_FLAGS, 16'h0001);
    rd_check("flag cleared", `SVDC_ADDR_FLAGS, 16'h0000);
    wr(`SVDC_ADDR_CTRL, 16'h0501);
    repeat (4) @(posedge clk_sys_in);
    check("threshold live", 16'h0005, {11'h000, threshold_select_out});
    rd_check("result after threshold", `SVDC_ADDR_FLAGS, 16'h0000);
  endtask

  task automatic gate_case(input logic sl, st, dg, dr, input logic [1:0] src, input logic exp);
    logic seen;
    wr(`SVDC_ADDR_CLOCK_CTRL, {7'h00, dr, 6'h18, src});
    @(posedge clk_sys_in);
    sleep_in             <= sl;
    source_sleep_stop_in <= st;
    debug_in             <= dg;
    seen = 1'b0;
    repeat (4) begin
      @(negedge clk_sys_in);
      seen = seen | detector_tick_out;
    end
    check("detector tick", {15'h0000, exp}, {15'h0000, seen});
    @(posedge clk_sys_in);
    sleep_in <= 1'b0;
    debug_in <= 1'b0;
  endtask

  task automatic interm_case(input logic [1:0] sc, input int lows);
    int   rises;
    logic prev;
    wr(`SVDC_ADDR_CTRL, {1'b0, sc, 5'h1E, 5'h00, 2'h1, 1'b0});
    wr(`SVDC_ADDR_FLAGS, 16'h0001);
    wr(`SVDC_ADDR_CTRL, {1'b0, sc, 5'h1E, 5'h00, 2'h1, 1'b1});
    rises = 0;
    prev  = 1'b0;
    for (int i = 0; i < 200 && irq_out !== 1'b1; i++) begin
      @(negedge clk_sys_in);
      if (comp_enable_out === 1'b1 && !prev) rises++;
      prev = comp_enable_out;
    end
    check("successive lows", lows[15:0], rises[15:0]);
    wr(`SVDC_ADDR_CTRL, 16'h1E02);
  endtask

  task automatic reset_scn();
    wr(`SVDC_ADDR_FLAGS, 16'h0001);
    wr(`SVDC_ADDR_CTRL, 16'h1EA3);
    for (int i = 0; i < 100 && svd_reset_out !== 1'b1; i++) @(negedge clk_sys_in);
    check("reset issued", 16'h0001, {15'h0000, svd_reset_out});
    rd_check("reset state ctrl", `SVDC_ADDR_CTRL, 16'h1EA1);
    rd_check("reset state ie", `SVDC_ADDR_INT_ENABLE, 16'h0000);
    rd_check("no flag in reset", `SVDC_ADDR_FLAGS, 16'h0100);
    @(posedge clk_sys_in);
    comp_low_in <= 1'b0;
    for (int i = 0; i < 10 && svd_reset_out !== 1'b0; i++) @(negedge clk_sys_in);
    check("reset released", 16'h0000, {15'h0000, svd_reset_out});
  endtask

  initial begin
    resetn_in = 1'b0;
    {wr_in, rd_in, sleep_in, source_sleep_stop_in, debug_in, comp_low_in} = 6'h00;
    addr_in = 3'h0;
    wdata_in = 16'h0000;
    src_tick_in = 4'hF;
    repeat (3) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    reset_values();
    protect_scn();
    continuous_scn();
    @(posedge clk_sys_in);
    src_tick_in <= 4'h1;
    gate_case(1'b0, 1'b0, 1'b0, 1'b1, 2'h0, 1'b1);
    gate_case(1'b1, 1'b1, 1'b0, 1'b1, 2'h0, 1'b0);
    gate_case(1'b1, 1'b0, 1'b0, 1'b1, 2'h0, 1'b1);
    gate_case(1'b0, 1'b0, 1'b1, 1'b0, 2'h0, 1'b0);
    gate_case(1'b0, 1'b0, 1'b1, 1'b1, 2'h0, 1'b1);
    gate_case(1'b0, 1'b0, 1'b0, 1'b1, 2'h1, 1'b0);
    src_tick_in <= 4'hF;
    wr(`SVDC_ADDR_CLOCK_CTRL, 16'h0160);
    wr(`SVDC_ADDR_INT_ENABLE, 16'h0001);
    comp_low_in <= 1'b1;
    interm_case(2'h0, 1);
    interm_case(2'h1, 2);
    interm_case(2'h2, 4);
    interm_case(2'h3, 8);
    reset_scn();
    close_out();
  end
endmodule // svdc_supply_voltage_detector_ctrl_bench

// File: verilog/svdc_supply_voltage_detector.sv
// supply voltage detector control: protected registers, clock divider, sampling, interrupt flag and reset
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`include "svdc_defs.svh"

// Behaviour
// (RQ1) Software unlocks with key 0x0096 before changing protected settings, then relocks.
// (RQ2) Software picks source and divider giving roughly 32 kHz detector clock.
// (RQ3) Sleep with source sleep-stop set halts detector, settings kept, resumes after.
// (RQ4) Debug with debug_run 0 suspends the detector clock, registers unchanged.
// (RQ5) Debug with debug_run 1 keeps the detector clock running.
// (RQ6) Enable bit 1 starts detection, 0 stops it.
// (RQ7) Result reads 0 at or above threshold, 1 below it.
// (RQ8) Software waits the enable response time before trusting the result.
// (RQ9) Software waits the response time after changing threshold.
// (RQ10) Threshold field selects one of 30 comparator levels.
// (RQ11) Mode 0 runs continuously and keeps updating the result.
// (RQ12) Low supply issues reset when reset_select is 0xA, else sets flag.
// (RQ13) Modes 1 to 3 power comparator at interval, sample once, power off.
// (RQ14) Intermittent event only after the selected number of successive lows.
// (RQ15) Software clears flag, sets interrupt enable, then sets enable last.
// (RQ16) Continuous detection keeps working without the detector clock after masking.
// (RQ17) Flag stays set after recovery, cleared only by writing 1.
// (RQ18) Interrupt request only while flag and enable are both set.
// (RQ19) Low count 0x3 needs eight successive lows, 0x2 needs four.
// (RQ20) Reset state forces continuous mode, clears fields, releases when result is 0.
// (RQ21) Protected writes ignored unless the key holds the unlock code.
// (RQ22) Successive-low counter restarts on a good sample or when disabled.
module svdc_supply_voltage_detector
  import svdc_pkg::*;
#(
  parameter int MASK_TICKS   = `SVDC_MASK_TICKS,
  parameter int INTERVAL_MD1 = `SVDC_INTERVAL_MD1,
  parameter int INTERVAL_MD2 = `SVDC_INTERVAL_MD2,
  parameter int INTERVAL_MD3 = `SVDC_INTERVAL_MD3
) (
  // clock and reset
  input  wire logic                    clk_sys_in,
  input  wire logic                    resetn_in,
  // register port
  input  wire logic [`SVDC_ADDR_W-1:0] addr_in,
  input  wire logic [`SVDC_DATA_W-1:0] wdata_in,
  input  wire logic                    wr_in,
  input  wire logic                    rd_in,
  output logic      [`SVDC_DATA_W-1:0] rdata_out,
  // clock sources and power states
  input  wire logic [3:0]              src_tick_in,
  input  wire logic                    sleep_in,
  input  wire logic                    source_sleep_stop_in,
  input  wire logic                    debug_in,
  // analog comparator on the monitored supply pin
  input  wire logic                    comp_low_in,
  output logic                         comp_enable_out,
  output logic      [4:0]              threshold_select_out,
  // results
  output logic                         irq_out,
  output logic                         svd_reset_out,
  output logic                         detector_tick_out
);

  svdc_state_s r_reg;
  svdc_state_s r_next;

  logic        unlocked;
  logic        src_tick;
  logic        div_tick;
  logic        clock_run;
  logic        det_tick;
  logic        mask_done;
  logic        low_event;
  logic        flag_clear;
  logic [7:0]  div_ratio;
  logic [3:0]  low_need;
  logic [11:0] interval_limit;

  always_comb begin
    r_next         = r_reg;
    flag_clear     = 1'b0;
    low_event      = 1'b0;
    div_tick       = 1'b0;
    // (RQ21) key gates writes
    unlocked       = (r_reg.protect_key == `SVDC_PROTECT_UNLOCK);
    div_ratio      = `SVDC_DIV_BASE << r_reg.clock_divider_select;
    src_tick       = src_tick_in[r_reg.clock_source_select];
    // (RQ19) successive low count
    low_need       = 4'h1 << r_reg.low_count_select;
    case (r_reg.sampling_mode)
      2'h1:    interval_limit = 12'(INTERVAL_MD1);
      2'h2:    interval_limit = 12'(INTERVAL_MD2);
      default: interval_limit = 12'(INTERVAL_MD3);
    endcase

    // key register is open to any write; it only gates the protected ones
    // register writes
    if (wr_in) begin
      case (addr_in)
        `SVDC_ADDR_PROTECT: begin
          r_next.protect_key = wdata_in;
        end
        `SVDC_ADDR_CLOCK_CTRL: begin
          // (RQ21) protected clock settings
          if (unlocked) begin
            r_next.debug_run            = wdata_in[`SVDC_CLK_DEBUG_RUN_BIT];
            r_next.clock_divider_select = wdata_in[`SVDC_CLK_DIV_MSB:`SVDC_CLK_DIV_LSB];
            r_next.clock_source_select  = wdata_in[`SVDC_CLK_SRC_MSB:`SVDC_CLK_SRC_LSB];
          end
        end
        `SVDC_ADDR_CTRL: begin
          // (RQ21) protected control settings
          if (unlocked) begin
            // low count only taken together with an intermittent mode
            if (wdata_in[`SVDC_CTL_MD_MSB:`SVDC_CTL_MD_LSB] != `SVDC_MODE_CONTINUOUS) begin
              r_next.low_count_select = wdata_in[`SVDC_CTL_SC_MSB:`SVDC_CTL_SC_LSB];
            end
            // (RQ10) threshold to comparator
            r_next.threshold_select = wdata_in[`SVDC_CTL_THR_MSB:`SVDC_CTL_THR_LSB];
            r_next.reset_select     = wdata_in[`SVDC_CTL_RE_MSB:`SVDC_CTL_RE_LSB];
            r_next.sampling_mode    = wdata_in[`SVDC_CTL_MD_MSB:`SVDC_CTL_MD_LSB];
            // (RQ6) start or stop detection
            r_next.detect_enable    = wdata_in[`SVDC_CTL_EN_BIT];
          end
        end
        `SVDC_ADDR_FLAGS: begin
          flag_clear = wdata_in[`SVDC_FLAG_LOW_BIT];
        end
        `SVDC_ADDR_INT_ENABLE: begin
          r_next.low_voltage_int_enable = wdata_in[`SVDC_INTE_BIT];
        end
        default: begin
        end
      endcase
    end

    // source clock divider
    // divider 6 and 7 pass each source tick straight through
    if (src_tick) begin
      if (r_reg.clock_divider_select >= `SVDC_DIV_BYPASS_MIN) begin
        div_tick        = 1'b1;
        r_next.prescale = 7'h00;
      end else if ({1'b0, r_reg.prescale} >= div_ratio - 8'h01) begin
        div_tick        = 1'b1;
        r_next.prescale = 7'h00;
      end else begin
        r_next.prescale = r_reg.prescale + 7'h01;
      end
    end

    // continuous sampling runs on the system clock, so gating only stops ticks
    // (RQ3) sleep stop halts clock
    // (RQ4) debug suspends clock
    // (RQ5) debug_run keeps clock
    clock_run = r_reg.detect_enable & ~(sleep_in & source_sleep_stop_in) & ~(debug_in & ~r_reg.debug_run);
    det_tick  = div_tick & clock_run;
    // masking counts ticks from enable and saturates at its limit
    mask_done = (r_reg.mask_cnt == 4'(MASK_TICKS));

    if (!r_reg.detect_enable) begin
      // (RQ22) restart count when disabled
      r_next.low_cnt      = 4'h0;
      r_next.mask_cnt     = 4'h0;
      r_next.interval_cnt = 12'h000;
      r_next.phase        = SVDC_PH_IDLE;
    end else begin
      if (det_tick && !mask_done) begin
        r_next.mask_cnt = r_reg.mask_cnt + 4'h1;
      end
      if (r_reg.sampling_mode == `SVDC_MODE_CONTINUOUS || r_reg.reset_active) begin
        // (RQ11) continuous result update
        // (RQ16) no detector clock needed
        // (RQ7) result follows comparator
        r_next.detect_result = comp_low_in;
        low_event            = comp_low_in & mask_done;
        r_next.low_cnt       = 4'h0;
        r_next.phase         = SVDC_PH_IDLE;
      end else begin
        // wait the interval, power for one tick, sample on the next
        // (RQ13) intermittent power and sample
        case (r_reg.phase)
          SVDC_PH_IDLE: begin
            r_next.interval_cnt = 12'h000;
            r_next.phase        = SVDC_PH_WAIT;
          end
          SVDC_PH_WAIT: begin
            if (det_tick) begin
              if (r_reg.interval_cnt >= interval_limit - 12'h001) begin
                r_next.interval_cnt = 12'h000;
                r_next.phase        = SVDC_PH_POWER;
              end else begin
                r_next.interval_cnt = r_reg.interval_cnt + 12'h001;
              end
            end
          end
          SVDC_PH_POWER: begin
            if (det_tick) begin
              r_next.phase = SVDC_PH_SAMPLE;
            end
          end
          SVDC_PH_SAMPLE: begin
            if (det_tick) begin
              r_next.detect_result = comp_low_in;
              r_next.phase         = SVDC_PH_WAIT;
              if (comp_low_in) begin
                // (RQ14) event after successive lows
                if (r_reg.low_cnt + 4'h1 >= low_need) begin
                  low_event      = mask_done;
                  r_next.low_cnt = 4'h0;
                end else begin
                  r_next.low_cnt = r_reg.low_cnt + 4'h1;
                end
              end else begin
                // (RQ22) good sample restarts count
                r_next.low_cnt = 4'h0;
              end
            end
          end
          default: begin
            r_next.phase = SVDC_PH_IDLE;
          end
        endcase
      end
    end

    // set below the clear so an event in the clear cycle wins
    // (RQ17) cleared only by writing 1
    if (flag_clear) begin
      r_next.low_voltage_flag = 1'b0;
    end
    // (RQ12) reset or interrupt select
    if (low_event && r_reg.reset_select != `SVDC_RESET_CODE) begin
      r_next.low_voltage_flag = 1'b1;
    end
    // release looks at the registered result, one cycle after recovery
    // (RQ20) release once result clear
    if (r_reg.reset_active && !r_reg.detect_result) begin
      r_next.reset_active = 1'b0;
    end
    if (low_event && r_reg.reset_select == `SVDC_RESET_CODE) begin
      r_next.reset_active = 1'b1;
    end
    // a stuck result keeps the reset held even if software clears the enable
    // (RQ20) fields forced during reset
    if (r_next.reset_active) begin
      r_next.sampling_mode          = `SVDC_MODE_CONTINUOUS;
      r_next.low_count_select       = 2'h0;
      r_next.low_voltage_int_enable = 1'b0;
      r_next.debug_run              = `SVDC_INIT_DEBUG_RUN;
      r_next.clock_divider_select   = `SVDC_INIT_DIV;
      r_next.clock_source_select    = `SVDC_INIT_SRC;
    end

    // read data, one cycle after the strobe
    if (rd_in) begin
      r_next.rdata = 16'h0000;
      case (addr_in)
        `SVDC_ADDR_CLOCK_CTRL: begin
          r_next.rdata[`SVDC_CLK_DEBUG_RUN_BIT]                  = r_reg.debug_run;
          r_next.rdata[`SVDC_CLK_DIV_MSB:`SVDC_CLK_DIV_LSB] = r_reg.clock_divider_select;
          r_next.rdata[`SVDC_CLK_SRC_MSB:`SVDC_CLK_SRC_LSB] = r_reg.clock_source_select;
        end
        `SVDC_ADDR_CTRL: begin
          r_next.rdata[`SVDC_CTL_SC_MSB:`SVDC_CTL_SC_LSB]   = r_reg.low_count_select;
          r_next.rdata[`SVDC_CTL_THR_MSB:`SVDC_CTL_THR_LSB] = r_reg.threshold_select;
          r_next.rdata[`SVDC_CTL_RE_MSB:`SVDC_CTL_RE_LSB]   = r_reg.reset_select;
          r_next.rdata[`SVDC_CTL_MD_MSB:`SVDC_CTL_MD_LSB]   = r_reg.sampling_mode;
          r_next.rdata[`SVDC_CTL_EN_BIT]                     = r_reg.detect_enable;
        end
        `SVDC_ADDR_FLAGS: begin
          r_next.rdata[`SVDC_FLAG_LOW_BIT]    = r_reg.low_voltage_flag;
          r_next.rdata[`SVDC_FLAG_RESULT_BIT] = r_reg.detect_result;
        end
        `SVDC_ADDR_INT_ENABLE: begin
          r_next.rdata[`SVDC_INTE_BIT] = r_reg.low_voltage_int_enable;
        end
        default: begin
          r_next.rdata = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      // clear all, then the fields with non-zero reset values
      r_reg                  <= '0;
      r_reg.debug_run        <= `SVDC_INIT_DEBUG_RUN;
      r_reg.threshold_select <= `SVDC_INIT_THRESHOLD;
      r_reg.phase            <= SVDC_PH_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  // irq and comparator power decode registers only
  assign rdata_out            = r_reg.rdata;
  assign threshold_select_out = r_reg.threshold_select;
  // (RQ13) comparator powered only when sampling
  assign comp_enable_out      = r_reg.detect_enable & ((r_reg.sampling_mode == `SVDC_MODE_CONTINUOUS)
                                | r_reg.reset_active | (r_reg.phase == SVDC_PH_POWER)
                                | (r_reg.phase == SVDC_PH_SAMPLE));
  // (RQ18) flag and enable both set
  assign irq_out              = r_reg.low_voltage_flag & r_reg.low_voltage_int_enable;
  assign svd_reset_out        = r_reg.reset_active;
  assign detector_tick_out    = det_tick;

endmodule // svdc_supply_voltage_detector
